/* File: hw/iswt_defines.svh */
// Constants for the slave window translation block.
`ifndef ISWT_DEFINES_SVH
`define ISWT_DEFINES_SVH

// --------------------------------------------------------------------------
// Window register selectors on the configuration port
// --------------------------------------------------------------------------
`define ISWT_SEL_BASE 2'h0
`define ISWT_SEL_MASK 2'h1
`define ISWT_SEL_OFFSET 2'h2
`define ISWT_SEL_CTRL 2'h3

// --------------------------------------------------------------------------
// Field positions and reset values
// --------------------------------------------------------------------------
`define ISWT_MASK_WEN_BIT 0
`define ISWT_OFFSET_XAMO_MSB 1
`define ISWT_OFFSET_XAMO_LSB 0
`define ISWT_CTRL_DEST_MSB 31
`define ISWT_CTRL_DEST_LSB 16
`define ISWT_CTRL_PRIO_MSB 15
`define ISWT_CTRL_PRIO_LSB 14
`define ISWT_CTRL_WTYPE_MSB 13
`define ISWT_CTRL_WTYPE_LSB 12
`define ISWT_WIN_RESET 32'h0000_0000
`define ISWT_FLAG_RD_BIT 1
`define ISWT_FLAG_WR_BIT 0

// --------------------------------------------------------------------------
// Read size codes
// --------------------------------------------------------------------------
`define ISWT_RDSIZE_WORD 4'h8
`define ISWT_RDSIZE_B 4'hb
`define ISWT_RDSIZE_C 4'hc
`define ISWT_RDSIZE_D 4'hd
`define ISWT_RDSIZE_E 4'he
`define ISWT_RDSIZE_F 4'hf

`endif

/* File: hw/iswt_pkg.sv */
// Types and shared helpers of the slave window translation block.
package iswt_pkg;

  // ------------------------------------------------------------------------
  // State and mode types
  // ------------------------------------------------------------------------
  typedef enum logic [2:0] {RD_IDLE, RD_REQ, RD_DATA, RD_ERR} iswt_rd_state_t;
  typedef enum logic [2:0] {WR_IDLE, WR_HDR, WR_DAT, WR_NEXT, WR_DROP} iswt_wr_state_t;
  typedef enum logic [1:0] {WT_NWRITE, WT_NWRITE_R, WT_SWRITE, WT_RSVD} iswt_wtype_t;

  // Masked address compare of one window, low three bits ignored.
  function automatic logic iswt_win_hit(input logic [31:0] addr, input logic [31:0] base,
                                        input logic [31:0] mask, input logic wen);
    iswt_win_hit = wen && ((addr[31:3] & mask[31:3]) == base[31:3]);
  endfunction

endpackage

/* File: hw/iswt_size_encode.sv */
// Read size and word pointer encoding for the 32-bit datapath.
`timescale 1ns/10ps
`include "iswt_defines.svh"
module iswt_size_encode (
  // Request shape
  input wire logic [6:0] burstcount,
  input wire logic addr2,
  // Encoded fields
  output logic wdptr,
  output logic [3:0] rdsize,
  output logic misaligned
);

  // Sizes are rounded up to the next supported packet size.
  always_comb begin
    misaligned = (burstcount > 7'h01) && addr2;
    wdptr = 1'b0;
    rdsize = `ISWT_RDSIZE_WORD;
    if (burstcount <= 7'h01) begin
      wdptr = ~addr2;
      rdsize = `ISWT_RDSIZE_WORD;
    end else if (burstcount == 7'h02) begin
      rdsize = `ISWT_RDSIZE_B;
    end else if (burstcount <= 7'h04) begin
      wdptr = 1'b1;
      rdsize = `ISWT_RDSIZE_B;
    end else if (burstcount <= 7'h08) begin
      rdsize = `ISWT_RDSIZE_C;
    end else if (burstcount <= 7'h10) begin
      wdptr = 1'b1;
      rdsize = `ISWT_RDSIZE_C;
    end else if (burstcount <= 7'h18) begin
      rdsize = `ISWT_RDSIZE_D;
    end else if (burstcount <= 7'h20) begin
      wdptr = 1'b1;
      rdsize = `ISWT_RDSIZE_D;
    end else if (burstcount <= 7'h28) begin
      rdsize = `ISWT_RDSIZE_E;
    end else if (burstcount <= 7'h30) begin
      wdptr = 1'b1;
      rdsize = `ISWT_RDSIZE_E;
    end else if (burstcount <= 7'h38) begin
      rdsize = `ISWT_RDSIZE_F;
    end else begin
      wdptr = 1'b1;
      rdsize = `ISWT_RDSIZE_F;
    end
  end

endmodule

/* File: hw/iswt_top.sv */
// Slave-side window translation from local read/write bursts to remote requests.
`timescale 1ns/10ps
`include "iswt_defines.svh"
module iswt_top import iswt_pkg::*; #(
  parameter int NUM_WIN = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Window register write port
  input wire logic cfg_wr_en,
  input wire logic [3:0] cfg_wr_window,
  input wire logic [1:0] cfg_wr_sel,
  input wire logic [31:0] cfg_wr_data,
  // Status flags and interrupt
  input wire logic [1:0] irq_enable,
  input wire logic [1:0] irq_clear,
  output logic read_unmapped_flag,
  output logic write_unmapped_flag,
  output logic slave_mnt_irq,
  // Local read slave
  input wire logic rd_read,
  input wire logic [31:0] rd_address,
  input wire logic [6:0] rd_burstcount,
  output logic rd_waitrequest,
  output logic [31:0] rd_readdata,
  output logic rd_readdatavalid,
  output logic rd_readerror,
  // Local write slave
  input wire logic wr_write,
  input wire logic [31:0] wr_address,
  input wire logic [31:0] wr_writedata,
  input wire logic [3:0] wr_byteenable,
  input wire logic [6:0] wr_burstcount,
  output logic wr_waitrequest,
  // Remote read request
  output logic rreq_valid,
  input wire logic rreq_ready,
  output logic [30:0] rreq_addr,
  output logic rreq_wdptr,
  output logic [3:0] rreq_rdsize,
  output logic [1:0] rreq_prio,
  output logic [15:0] rreq_target_device_id,
  // Remote read response words
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_data,
  input wire logic rsp_last,
  // Remote write request header
  output logic wreq_valid,
  input wire logic wreq_ready,
  output logic [30:0] wreq_addr,
  output logic wreq_addr2,
  output logic [1:0] wreq_type,
  output logic [1:0] wreq_prio,
  output logic [15:0] wreq_target_device_id,
  output logic [6:0] wreq_burstcount,
  // Remote write data
  output logic wdata_valid,
  input wire logic wdata_ready,
  output logic [31:0] wdata,
  output logic [3:0] wdata_byteenable
);

  // ------------------------------------------------------------------------
  // Window registers
  // ------------------------------------------------------------------------
  logic [NUM_WIN-1:0][31:0] base_reg;
  logic [NUM_WIN-1:0][31:0] mask_reg;
  logic [NUM_WIN-1:0][31:0] offset_reg;
  logic [NUM_WIN-1:0][31:0] ctrl_reg;

  // Writes land at any time; in-flight requests keep their latched header.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      base_reg <= '0;
      mask_reg <= '0;
      offset_reg <= '0;
      ctrl_reg <= '0;
    end else if (cfg_wr_en && (32'(cfg_wr_window) < NUM_WIN)) begin
      case (cfg_wr_sel)
        `ISWT_SEL_BASE: base_reg[cfg_wr_window] <= cfg_wr_data;
        `ISWT_SEL_MASK: mask_reg[cfg_wr_window] <= cfg_wr_data;
        `ISWT_SEL_OFFSET: offset_reg[cfg_wr_window] <= cfg_wr_data;
        `ISWT_SEL_CTRL: ctrl_reg[cfg_wr_window] <= cfg_wr_data;
        default: base_reg <= base_reg;
      endcase
    end
  end

  // ------------------------------------------------------------------------
  // Translation for each direction
  // ------------------------------------------------------------------------
  logic rd_hit;
  logic [30:0] rd_xaddr;
  logic [31:0] rd_ctrl;
  logic wr_hit;
  logic [30:0] wr_xaddr;
  logic [31:0] wr_ctrl;
  logic enc_wdptr;
  logic [3:0] enc_rdsize;
  logic enc_misaligned;

  // Independent searches so both directions proceed together.
  iswt_window_match #(.NUM_WIN(NUM_WIN)) u_rd_match (
    .addr(rd_address),
    .base(base_reg),
    .mask(mask_reg),
    .offset(offset_reg),
    .ctrl(ctrl_reg),
    .hit(rd_hit),
    .remote_addr(rd_xaddr),
    .ctrl_sel(rd_ctrl)
  );

  iswt_window_match #(.NUM_WIN(NUM_WIN)) u_wr_match (
    .addr(wr_address),
    .base(base_reg),
    .mask(mask_reg),
    .offset(offset_reg),
    .ctrl(ctrl_reg),
    .hit(wr_hit),
    .remote_addr(wr_xaddr),
    .ctrl_sel(wr_ctrl)
  );

  iswt_size_encode u_size (
    .burstcount(rd_burstcount),
    .addr2(rd_address[2]),
    .wdptr(enc_wdptr),
    .rdsize(enc_rdsize),
    .misaligned(enc_misaligned)
  );

  // ------------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------------
  iswt_rd_state_t rd_state_reg, rd_state_next;
  logic [6:0] rd_burst_reg;
  logic [6:0] rd_cnt_reg;
  logic rd_accept;
  logic rd_bad;
  logic rd_set;

  assign rd_accept = rd_read && !rd_waitrequest;
  assign rd_bad = !rd_hit || enc_misaligned;
  assign rd_set = rd_accept && rd_bad;

  // Read sequencing: request out, then wait for the response words.
  always_comb begin
    rd_state_next = rd_state_reg;
    case (rd_state_reg)
      RD_IDLE: if (rd_accept) rd_state_next = rd_bad ? RD_ERR : RD_REQ;
      RD_REQ: if (rreq_ready) rd_state_next = RD_DATA;
      RD_DATA: if (rsp_valid && rsp_last) rd_state_next = RD_IDLE;
      RD_ERR: if (rd_cnt_reg + 7'h01 >= rd_burst_reg) rd_state_next = RD_IDLE;
      default: rd_state_next = RD_IDLE;
    endcase
  end

  // State and stall; the stall holds until the transfer is finished.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rd_state_reg <= RD_IDLE;
      rd_waitrequest <= 1'b1;
    end else begin
      rd_state_reg <= rd_state_next;
      rd_waitrequest <= (rd_state_next != RD_IDLE);
    end
  end

  // Burst length and beat count.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rd_burst_reg <= 7'h00;
      rd_cnt_reg <= 7'h00;
    end else if (rd_accept) begin
      rd_burst_reg <= (rd_burstcount == 7'h00) ? 7'h01 : rd_burstcount;
      rd_cnt_reg <= 7'h00;
    end else if ((rd_state_reg == RD_ERR) ||
                 (rd_state_reg == RD_DATA && rsp_valid && rd_cnt_reg < rd_burst_reg)) begin
      rd_cnt_reg <= rd_cnt_reg + 7'h01;
    end
  end

  // Remote read request header, latched from the window at acceptance.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rreq_valid <= 1'b0;
      rreq_addr <= '0;
      rreq_wdptr <= 1'b0;
      rreq_rdsize <= 4'h0;
      rreq_prio <= 2'h0;
      rreq_target_device_id <= 16'h0000;
    end else if (rd_accept && !rd_bad) begin
      rreq_valid <= 1'b1;
      rreq_addr <= rd_xaddr;
      rreq_wdptr <= enc_wdptr;
      rreq_rdsize <= enc_rdsize;
      rreq_prio <= rd_ctrl[`ISWT_CTRL_PRIO_MSB:`ISWT_CTRL_PRIO_LSB];
      rreq_target_device_id <= rd_ctrl[`ISWT_CTRL_DEST_MSB:`ISWT_CTRL_DEST_LSB];
    end else if (rreq_ready) begin
      rreq_valid <= 1'b0;
    end
  end

  // Beats to the local master: surplus words of a rounded-up packet are dropped.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rd_readdatavalid <= 1'b0;
      rd_readerror <= 1'b0;
      rd_readdata <= 32'h0000_0000;
    end else begin
      rd_readdatavalid <= (rd_state_reg == RD_ERR) ||
                          (rd_state_reg == RD_DATA && rsp_valid && rd_cnt_reg < rd_burst_reg);
      rd_readerror <= (rd_state_reg == RD_ERR);
      rd_readdata <= (rd_state_reg == RD_DATA) ? rsp_data : 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------------------
  // Write path
  // ------------------------------------------------------------------------
  iswt_wr_state_t wr_state_reg, wr_state_next;
  logic [6:0] wr_rem_reg;
  logic wr_accept;
  logic wr_bad;
  logic wr_set;

  assign wr_accept = wr_write && !wr_waitrequest;
  assign wr_bad = !wr_hit || ((wr_burstcount > 7'h01) && wr_address[2]);
  assign wr_set = wr_accept && (wr_state_reg == WR_IDLE) && wr_bad;

  // Write sequencing: header, then one data word per local beat.
  always_comb begin
    wr_state_next = wr_state_reg;
    case (wr_state_reg)
      WR_IDLE: begin
        if (wr_accept && wr_bad) begin
          wr_state_next = (wr_burstcount > 7'h01) ? WR_DROP : WR_IDLE;
        end else if (wr_accept) begin
          wr_state_next = WR_HDR;
        end
      end
      WR_HDR: if (wreq_ready) wr_state_next = WR_DAT;
      WR_DAT: if (wdata_ready) wr_state_next = (wr_rem_reg == 7'h00) ? WR_IDLE : WR_NEXT;
      WR_NEXT: if (wr_accept) wr_state_next = WR_DAT;
      WR_DROP: if (wr_accept && wr_rem_reg <= 7'h01) wr_state_next = WR_IDLE;
      default: wr_state_next = WR_IDLE;
    endcase
  end

  // State, stall and remaining beats of the burst.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_state_reg <= WR_IDLE;
      wr_waitrequest <= 1'b1;
      wr_rem_reg <= 7'h00;
    end else begin
      wr_state_reg <= wr_state_next;
      wr_waitrequest <= !(wr_state_next == WR_IDLE || wr_state_next == WR_NEXT ||
                          wr_state_next == WR_DROP);
      if (wr_accept && wr_state_reg == WR_IDLE) begin
        wr_rem_reg <= (wr_burstcount == 7'h00) ? 7'h00 : wr_burstcount - 7'h01;
      end else if (wr_accept) begin
        wr_rem_reg <= wr_rem_reg - 7'h01;
      end
    end
  end

  // Write request header from the matching window.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wreq_valid <= 1'b0;
      wreq_addr <= '0;
      wreq_addr2 <= 1'b0;
      wreq_type <= WT_NWRITE;
      wreq_prio <= 2'h0;
      wreq_target_device_id <= 16'h0000;
      wreq_burstcount <= 7'h00;
    end else if (wr_accept && wr_state_reg == WR_IDLE && !wr_bad) begin
      wreq_valid <= 1'b1;
      wreq_addr <= wr_xaddr;
      wreq_addr2 <= wr_address[2];
      wreq_type <= wr_ctrl[`ISWT_CTRL_WTYPE_MSB:`ISWT_CTRL_WTYPE_LSB];
      wreq_prio <= wr_ctrl[`ISWT_CTRL_PRIO_MSB:`ISWT_CTRL_PRIO_LSB];
      wreq_target_device_id <= wr_ctrl[`ISWT_CTRL_DEST_MSB:`ISWT_CTRL_DEST_LSB];
      wreq_burstcount <= wr_burstcount;
    end else if (wreq_ready) begin
      wreq_valid <= 1'b0;
    end
  end

  // Data words; valid rises once the header has been taken.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wdata_valid <= 1'b0;
      wdata <= 32'h0000_0000;
      wdata_byteenable <= 4'h0;
    end else begin
      if (wr_accept && wr_state_reg != WR_DROP && !(wr_state_reg == WR_IDLE && wr_bad)) begin
        wdata <= wr_writedata;
        wdata_byteenable <= wr_byteenable;
      end
      wdata_valid <= (wr_state_next == WR_DAT) && !(wr_state_reg == WR_DAT && wdata_ready);
    end
  end

  // ------------------------------------------------------------------------
  // Unmapped flags and interrupt
  // ------------------------------------------------------------------------
  logic [1:0] flags_set;
  assign flags_set = {rd_set, wr_set};

  // Write-one-to-clear; a new event in the same cycle keeps its flag set.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      read_unmapped_flag <= 1'b0;
      write_unmapped_flag <= 1'b0;
      slave_mnt_irq <= 1'b0;
    end else begin
      read_unmapped_flag <= (read_unmapped_flag && !irq_clear[`ISWT_FLAG_RD_BIT]) ||
                            flags_set[`ISWT_FLAG_RD_BIT];
      write_unmapped_flag <= (write_unmapped_flag && !irq_clear[`ISWT_FLAG_WR_BIT]) ||
                             flags_set[`ISWT_FLAG_WR_BIT];
      slave_mnt_irq <= |({read_unmapped_flag, write_unmapped_flag} & irq_enable);
    end
  end

  // ------------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------------
  sequence s_rd_good_accept;
    rd_accept && rd_hit && !enc_misaligned;
  endsequence

  sequence s_rd_hdr_out;
    ##1 rreq_valid && rd_state_reg == RD_REQ;
  endsequence

  a_rd_unmapped_flag: assert property (@(posedge clk_sys) disable iff (reset)
    rd_accept && !rd_hit |=> read_unmapped_flag)
    else $error("read miss did not set flag");

  a_rd_misalign_err: assert property (@(posedge clk_sys) disable iff (reset)
    rd_accept && rd_burstcount == 7'h04 && rd_address[2] |=>
      read_unmapped_flag ##1 (rd_readdatavalid && rd_readerror) [*4] ##1 !rd_readdatavalid)
    else $error("misaligned burst beats wrong");

  a_rd_hdr_xlate: assert property (@(posedge clk_sys) disable iff (reset)
    s_rd_good_accept |-> s_rd_hdr_out ##0 rreq_addr == $past(rd_xaddr) &&
      rreq_prio == $past(rd_ctrl[15:14]) && rreq_target_device_id == $past(rd_ctrl[31:16]))
    else $error("read header not taken from window");

  a_rd_single_size: assert property (@(posedge clk_sys) disable iff (reset)
    s_rd_good_accept ##0 rd_burstcount == 7'h01 |=>
      rreq_rdsize == 4'h8 && rreq_wdptr == !$past(rd_address[2]))
    else $error("single read size wrong");

  a_rd_no_early_data: assert property (@(posedge clk_sys) disable iff (reset)
    rd_readdatavalid && !rd_readerror |-> $past(rsp_valid))
    else $error("read data without response");

  a_rd_word_limit: assert property (@(posedge clk_sys) disable iff (reset)
    rd_state_reg != RD_IDLE |-> rd_cnt_reg <= rd_burst_reg)
    else $error("too many words returned");

  a_lowest_window: assert property (@(posedge clk_sys) disable iff (reset)
    rd_hit && iswt_win_hit(rd_address, base_reg[0], mask_reg[0], mask_reg[0][0]) |->
      rd_ctrl == ctrl_reg[0])
    else $error("window zero did not win");

  a_flag_set_wins: assert property (@(posedge clk_sys) disable iff (reset)
    wr_set && irq_clear[0] |=> write_unmapped_flag)
    else $error("clear beat a new event");

  a_flag_w1c: assert property (@(posedge clk_sys) disable iff (reset)
    irq_clear[1] && !rd_set |=> !read_unmapped_flag ##1 !slave_mnt_irq || write_unmapped_flag)
    else $error("flag not cleared");

  a_cfg_write: assert property (@(posedge clk_sys) disable iff (reset)
    cfg_wr_en && cfg_wr_sel == 2'h3 && cfg_wr_window == 4'h0 |=>
      ctrl_reg[0] == $past(cfg_wr_data))
    else $error("window write lost");

  a_wr_unmapped: assert property (@(posedge clk_sys) disable iff (reset)
    wr_accept && wr_state_reg == WR_IDLE && !wr_hit |=> write_unmapped_flag && !wreq_valid)
    else $error("write miss not flagged");

endmodule

/* File: hw/iswt_window_match.sv */
// Window search: picks the lowest enabled window that matches an address.
`timescale 1ns/10ps
`include "iswt_defines.svh"
module iswt_window_match import iswt_pkg::*; #(
  parameter int NUM_WIN = 16
) (
  // Local address
  input wire logic [31:0] addr,
  // Window registers
  input wire logic [NUM_WIN-1:0][31:0] base,
  input wire logic [NUM_WIN-1:0][31:0] mask,
  input wire logic [NUM_WIN-1:0][31:0] offset,
  input wire logic [NUM_WIN-1:0][31:0] ctrl,
  // Result
  output logic hit,
  output logic [30:0] remote_addr,
  output logic [31:0] ctrl_sel
);

  // Scan downward so the lowest matching window is written last and wins.
  always_comb begin
    hit = 1'b0;
    remote_addr = '0;
    ctrl_sel = '0;
    for (int i = NUM_WIN - 1; i >= 0; i--) begin
      if (iswt_win_hit(addr, base[i], mask[i], mask[i][`ISWT_MASK_WEN_BIT])) begin
        hit = 1'b1;
        remote_addr = {offset[i][`ISWT_OFFSET_XAMO_MSB:`ISWT_OFFSET_XAMO_LSB],
                       (offset[i][31:3] & mask[i][31:3]) | (addr[31:3] & ~mask[i][31:3])};
        ctrl_sel = ctrl[i];
      end
    end
  end

endmodule

/* File: test/iswt_remote_model.sv */
// Behavioural remote element that answers read and write requests.
`timescale 1ns/10ps
module iswt_remote_model (
  // Clock and pacing
  input wire logic clk_sys,
  input wire logic slow,
  // Read request and response
  input wire logic rreq_valid,
  output logic rreq_ready,
  input wire logic rreq_wdptr,
  input wire logic [3:0] rreq_rdsize,
  output logic rsp_valid,
  output logic [31:0] rsp_data,
  output logic rsp_last,
  // Write handshakes
  output logic wreq_ready,
  output logic wdata_ready
);
  // ------------------------------------------------------------------
  // Responder
  // ------------------------------------------------------------------
  logic tog = 1'b0;

  // Write side takes headers at once and stalls data every other cycle when slow.
  always @(posedge clk_sys) tog <= ~tog;
  assign wreq_ready = 1'b1;
  assign wdata_ready = !slow || tog;

  // Read side returns a whole packet of the rounded-up size for each request.
  always begin : rd_side
    int n;
    rreq_ready = 1'b0;
    rsp_valid = 1'b0;
    rsp_last = 1'b0;
    @(posedge clk_sys iff rreq_valid === 1'b1);
    if (slow) repeat (3) @(posedge clk_sys);
    n = (rreq_rdsize == 4'h8) ? 1 : (rreq_rdsize == 4'hb) ? 2 << rreq_wdptr :
        8 * (2 * (int'(rreq_rdsize) - 12) + int'(rreq_wdptr) + 1);
    #1 rreq_ready = 1'b1;
    @(posedge clk_sys);
    #1 rreq_ready = 1'b0;
    for (int i = 0; i < n; i++) begin
      rsp_valid = 1'b1;
      rsp_data = 32'ha000_0000 + 32'(i);
      rsp_last = (i == n - 1);
      @(posedge clk_sys);
      #1;
    end
    rsp_data = ~rsp_data;
  end
endmodule

/* File: test/tb_top.sv */
// Self-checking bench for the slave window translation block.
`timescale 1ns/10ps
module tb_top;
  // ------------------------------------------------------------------
  // Signals, design and remote model
  // ------------------------------------------------------------------
  logic clk_sys = 1'b0, reset = 1'b1, slow = 1'b0, cfg_wr_en = 1'b0, rd_read = 1'b0;
  logic wr_write = 1'b0;
  logic [3:0] cfg_wr_window = 4'h0, wr_byteenable = 4'hf;
  logic [1:0] cfg_wr_sel = 2'h0, irq_enable = 2'h2, irq_clear = 2'h0;
  logic [31:0] cfg_wr_data = 32'h0, rd_address = 32'h0, wr_address = 32'h0;
  logic [31:0] wr_writedata = 32'h0, rd_readdata, rsp_data, wdata, last_d;
  logic [6:0] rd_burstcount = 7'h1, wr_burstcount = 7'h1, wreq_burstcount;
  logic read_unmapped_flag, write_unmapped_flag, slave_mnt_irq, rd_waitrequest;
  logic rd_readdatavalid, rd_readerror, wr_waitrequest, rreq_valid, rreq_ready, rreq_wdptr;
  logic rsp_valid, rsp_last, wreq_valid, wreq_ready, wreq_addr2, wdata_valid, wdata_ready;
  logic [30:0] rreq_addr, wreq_addr;
  logic [3:0] rreq_rdsize, wdata_byteenable;
  logic [1:0] rreq_prio, wreq_type, wreq_prio;
  logic [15:0] rreq_target_device_id, wreq_target_device_id;
  logic [53:0] rhdr;
  logic [50:0] whdr;
  logic [43:0] wd;
  int error_cnt = 0, n_tests = 0, beats = 0, errs = 0, nreq = 0;

  iswt_top #(.NUM_WIN(2)) uut (.clk_sys, .reset, .cfg_wr_en, .cfg_wr_window, .cfg_wr_sel,
    .cfg_wr_data, .irq_enable, .irq_clear, .read_unmapped_flag, .write_unmapped_flag,
    .slave_mnt_irq, .rd_read, .rd_address, .rd_burstcount, .rd_waitrequest, .rd_readdata,
    .rd_readdatavalid, .rd_readerror, .wr_write, .wr_address, .wr_writedata, .wr_byteenable,
    .wr_burstcount, .wr_waitrequest, .rreq_valid, .rreq_ready, .rreq_addr, .rreq_wdptr,
    .rreq_rdsize, .rreq_prio, .rreq_target_device_id, .rsp_valid, .rsp_data, .rsp_last,
    .wreq_valid, .wreq_ready, .wreq_addr, .wreq_addr2, .wreq_type, .wreq_prio,
    .wreq_target_device_id, .wreq_burstcount, .wdata_valid, .wdata_ready, .wdata,
    .wdata_byteenable);
  iswt_remote_model partner (.clk_sys, .slow, .rreq_valid, .rreq_ready, .rreq_wdptr,
    .rreq_rdsize, .rsp_valid, .rsp_data, .rsp_last, .wreq_ready, .wdata_ready);

  // The clock toggles every half period of 20 ns.
  always #20 clk_sys = ~clk_sys;

  // Beats and accepted remote headers are captured at each rising edge.
  always @(posedge clk_sys) begin
    if (rd_readdatavalid === 1'b1) begin
      beats++;
      errs += int'(rd_readerror);
      last_d = rd_readdata;
    end
    if (rreq_valid && rreq_ready) begin
      rhdr = {rreq_addr, rreq_wdptr, rreq_rdsize, rreq_prio, rreq_target_device_id};
      nreq++;
    end
    if (wreq_valid && wreq_ready) whdr = {wreq_addr, wreq_type, wreq_prio, wreq_target_device_id};
    if (wdata_valid && wdata_ready) wd = {wreq_addr2, wreq_burstcount, wdata, wdata_byteenable};
  end

  // Expected remote address bits 33 to 3 and expected word pointer with read size.
  function automatic logic [30:0] ea(input logic [31:0] a, m, o);
    logic [31:0] t;
    t = (o & m) | (a & ~m);
    return {o[1:0], t[31:3]};
  endfunction
  function automatic logic [4:0] sz(input int bc, input logic a2);
    int g;
    g = (bc - 1) / 8;
    if (bc == 1) return {~a2, 4'h8};
    if (bc <= 4) return {bc > 2, 4'hb};
    return {g[0], 4'hc + 4'(g / 2)};
  endfunction

  task automatic chk(input string nm, input logic [63:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
      error_cnt++;
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Waits, bounded, until both local slaves are idle; strobes from earlier steps drop here.
  task automatic wait_idle;
    int k;
    k = 0;
    cfg_wr_en = 1'b0;
    irq_clear = 2'h0;
    do begin
      @(posedge clk_sys);
      k++;
    end while ((rd_waitrequest | wr_waitrequest) !== 1'b0 && k < 300);
    if (k >= 300) begin
      error_cnt++;
      complete_run();
    end
    @(posedge clk_sys);
    #1;
  endtask
  task automatic cfg(input int w, s, input logic [31:0] d);
    cfg_wr_en = 1'b1;
    cfg_wr_window = 4'(w);
    cfg_wr_sel = 2'(s);
    cfg_wr_data = d;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic rd(input logic [31:0] a, input logic [6:0] bc);
    wait_idle();
    beats = 0;
    errs = 0;
    rd_read = 1'b1;
    rd_address = a;
    rd_burstcount = bc;
    @(posedge clk_sys);
    #1 rd_read = 1'b0;
    rd_address = ~a;
    for (int k = 0; beats < bc && k < 300; k++) @(posedge clk_sys);
    if (beats < bc) begin
      error_cnt++;
      complete_run();
    end
    wait_idle();
  endtask
  task automatic wr(input logic [31:0] a, d);
    wait_idle();
    wr_write = 1'b1;
    irq_clear = 2'h1; // A clear that meets a miss must lose to the new event.
    wr_address = a;
    wr_writedata = d;
    @(posedge clk_sys);
    #1 wr_write = 1'b0;
    wait_idle();
  endtask
  task automatic clr;
    irq_clear = 2'h3;
    @(posedge clk_sys);
    #1;
    wait_idle();
  endtask

  // Main sequence: reset, program two windows, then reads and writes.
  initial begin
    logic [31:0] wv [8];
    int bl [12];
    int n0;
    wv = '{32'h4000_0005, 32'hc000_0003, 32'h8000_0006, 32'h00ab_8000,
           32'h4000_0000, 32'hc000_0001, 32'h0000_0001, 32'h0011_4000};
    bl = '{1, 2, 3, 4, 5, 16, 17, 32, 33, 48, 49, 64};
    repeat (3) @(posedge clk_sys);
    #1 reset = 1'b0;
    wait_idle();
    chk("flags", {read_unmapped_flag, write_unmapped_flag, slave_mnt_irq}, 3'h0);
    for (int i = 0; i < 8; i++) cfg(i / 4, i % 4, wv[i]);
    rd(32'h4000_0104, 7'h1);
    chk("hdr", rhdr, {ea(32'h4000_0104, wv[1], wv[2]), 5'h08, 2'h2, 16'h00ab});
    chk("data", {last_d, errs}, {32'ha000_0000, 32'd0});
    $display("single read test done");
    foreach (bl[i]) begin
      slow = bl[i][0];
      rd(32'h4000_0100, 7'(bl[i]));
      chk("size", rhdr[22:18], sz(bl[i], 1'b0));
      chk("beats", {beats, last_d}, {bl[i], 32'ha000_0000 + 32'(bl[i] - 1)});
    end
    $display("burst size test done");
    n0 = nreq;
    rd(32'h4000_0104, 7'h4);
    chk("err beats", {beats, errs}, {32'd4, 32'd4});
    chk("err nreq", nreq, n0);
    chk("rd flag", {read_unmapped_flag, slave_mnt_irq}, 2'h3);
    clr();
    chk("cleared", {read_unmapped_flag, slave_mnt_irq}, 2'h0);
    rd(32'h0000_0020, 7'h2);
    chk("rd miss", {read_unmapped_flag, beats[30:0], errs}, {1'b1, 31'd2, 32'd2});
    clr();
    $display("misaligned read test done");
    wr(32'h0000_0010, 32'h1);
    chk("wr flag", {write_unmapped_flag, slave_mnt_irq}, 2'h2);
    clr();
    $display("unmapped write test done");
    cfg(0, 1, 32'hc000_0000);
    for (int t = 0; t < 3; t++) begin
      cfg(1, 1, 32'hc000_0000);
      cfg(1, 3, {16'h0011, 2'h1, 2'(t), 12'h0});
      cfg(1, 1, wv[5]);
      wr(32'h4000_020c, 32'h5a5a_0000 + 32'(t));
      chk("wr hdr", whdr, {ea(32'h4000_020c, wv[5], wv[6]), 2'(t), 2'h1, 16'h0011});
      chk("wr data", wd, {1'b1, 7'h01, 32'h5a5a_0000 + 32'(t), 4'hf});
    end
    $display("write type test done");
    complete_run();
  end
endmodule
